//--- pkg/cpm_pkg.sv
package cpm_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ADDR_MISC_SYSTEM_CONTROL  = 32'h5600_0080;
  localparam logic [31:0] ADDR_PORT_PIN_CONFIG      = 32'h5600_00D0;
  localparam logic [31:0] ADDR_PORT_PIN_DATA        = 32'h5600_00D4;
  localparam logic [31:0] ADDR_PORT_PULLUP_DISABLE  = 32'h5600_00D8;
  localparam logic [31:0] ADDR_IRQ_STATUS           = 32'h5600_00E0;
  localparam logic [31:0] ADDR_IRQ_MASK             = 32'h5600_00E4;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [31:0] RST_MISC_SYSTEM_CONTROL   = 32'h0001_0020;
  localparam logic [25:0] RST_PORT_PIN_CONFIG       = 26'h000_0000;
  localparam logic [12:0] RST_PORT_PULLUP_DISABLE   = 13'h0000;

  // Writable bits of the miscellaneous register; reserved bits read zero.
  localparam logic [31:0] MISC_WRITE_MASK           = 32'h007F_377B;

  // ---------------------------------------------------------------------------
  // Field positions of the miscellaneous register
  // ---------------------------------------------------------------------------
  localparam int BATT_SEL_LSB        = 20;
  localparam int SELF_REFRESH_BIT    = 19;
  localparam int MEMCLK1_GATE_BIT    = 18;
  localparam int MEMCLK0_GATE_BIT    = 17;
  localparam int RESET_OUT_BIT       = 16;
  localparam int USB1_SUSPEND_BIT    = 13;
  localparam int USB0_SUSPEND_BIT    = 12;
  localparam int CLOCK_OUT_PAD1_SRC_LSB     = 8;
  localparam int CLOCK_OUT_PAD0_SRC_LSB     = 4;
  localparam int USB_PAD_ROLE_BIT    = 3;
  localparam int UPPER_PULLUP_BIT    = 1;
  localparam int LOWER_PULLUP_BIT    = 0;

  // Interrupt status bits.
  localparam int IRQ_BATT_FAULT_BIT  = 0;
  localparam int IRQ_WIDTH           = 1;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    CPM_PIN_INPUT  = 2'h0,
    CPM_PIN_OUTPUT = 2'h1,
    CPM_PIN_CAMERA = 2'h2,
    CPM_PIN_RSVD   = 2'h3
  } cpm_pin_mode_t;

  localparam logic [2:0] CLKSRC_PLL_OR_XTAL = 3'h0;
  localparam logic [2:0] CLKSRC_USB_PLL     = 3'h1;
  localparam logic [2:0] CLKSRC_RTC_OR_CORE = 3'h2;
  localparam logic [2:0] CLKSRC_BUS         = 3'h3;
  localparam logic [2:0] CLKSRC_PERIPH      = 3'h4;
  localparam logic [2:0] CLKSRC_DIVIDED     = 3'h5;

  localparam logic [2:0] BATT_SEL_IGNORE    = 3'h6;
  localparam logic [2:0] BATT_SEL_OFF       = 3'h7;

endpackage

//--- hdl/cpm_camera_port.sv
`timescale 1ns/10ps
`default_nettype none
module cpm_camera_port #(
  parameter int PINS = 13
) (
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire logic [31:0]       addr_in,
  input  wire logic [31:0]       wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [31:0]       rdata_out,
  output logic                   irq_out,
  input  wire logic [PINS-1:0]   pin_in,
  output logic      [PINS-1:0]   pin_out,
  output logic      [PINS-1:0]   pin_oe_b_out,
  output logic      [PINS-1:0]   pin_pullup_en_out,
  output logic      [PINS-1:0]   pin_camera_sel_out,
  input  wire logic [PINS-1:0]   camera_func_out_in,
  input  wire logic [PINS-1:0]   camera_func_oe_in,
  output logic      [PINS-1:0]   camera_func_in_out,
  input  wire logic              battery_fault_in_n,
  input  wire logic              sleep_mode_in,
  output logic                   batt_hold_reset_out,
  output logic                   batt_wakeup_out,
  output logic                   wakeup_block_out,
  output logic                   self_refresh_retain_out,
  input  wire logic              memclk_in,
  output logic                   memclk_out1,
  output logic                   memclk_out0,
  output logic                   reset_out_n,
  output logic                   usb_port1_suspend_out,
  output logic                   usb_port0_suspend_out,
  output logic                   usb_pad_role_select_out,
  input  wire logic [5:0]        clock_out_pad1_sources_in,
  input  wire logic [5:0]        clock_out_pad0_sources_in,
  output logic                   clock_out_pad1,
  output logic                   clock_out_pad0,
  output logic                   upper_bus_pullup_off_out,
  output logic                   lower_bus_pullup_off_out
);

  // The pin map and its register fields are fixed at thirteen pins.
  if (PINS != 13)
  begin : g_pins_check
    $error("cpm_camera_port serves exactly 13 pins");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  localparam int IRQ_W = cpm_pkg::IRQ_WIDTH;

  typedef struct packed {
    logic [31:0]     misc;
    logic [25:0]     cfg;
    logic [12:0]     dat;
    logic [12:0]     pud;
    logic [12:0]     pin_s1;
    logic [12:0]     pin_s2;
    logic            bf_s1;
    logic            bf_s2;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_msk;
    logic [31:0]     rdata;
  } cpm_state_t;

  cpm_state_t state_reg;
  cpm_state_t state_next;

  logic [2:0]  batt_sel;
  logic        batt_active;
  logic        batt_evt;
  logic [31:0] rd_word;
  logic [12:0] out_en;
  logic [12:0] cam_sel;
  logic [2:0]  src1;
  logic [2:0]  src0;

  assign batt_sel = state_reg.misc[cpm_pkg::BATT_SEL_LSB +: 3];
  assign batt_active = !state_reg.bf_s2;
  assign src1 = state_reg.misc[cpm_pkg::CLOCK_OUT_PAD1_SRC_LSB +: 3];
  assign src0 = state_reg.misc[cpm_pkg::CLOCK_OUT_PAD0_SRC_LSB +: 3];

  // ---------------------------------------------------------------------------
  // Per-pin mode decode
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 13; g++)
    begin : g_pin
      cpm_pkg::cpm_pin_mode_t mode;
      assign mode = cpm_pkg::cpm_pin_mode_t'(state_reg.cfg[2*g +: 2]);
      assign out_en[g]  = (mode == cpm_pkg::CPM_PIN_OUTPUT);
      assign cam_sel[g] = (mode == cpm_pkg::CPM_PIN_CAMERA);
      // Reserved mode leaves the pin undriven, like input.
      assign pin_out[g] = cam_sel[g] ? camera_func_out_in[g] : state_reg.dat[g];
      assign pin_oe_b_out[g] = !(out_en[g] || (cam_sel[g] && camera_func_oe_in[g]));
      assign pin_pullup_en_out[g] = !state_reg.pud[g];
      assign camera_func_in_out[g] = cam_sel[g] ? state_reg.pin_s2[g] : 1'b0;
    end
  endgenerate

  assign pin_camera_sel_out = cam_sel;

  // ---------------------------------------------------------------------------
  // Battery fault handling
  // ---------------------------------------------------------------------------
  // Bit 2 clear selects hold-in-reset; that is also the reset value, so software
  // must move the field after boot or a fault will keep the part in reset.
  assign batt_hold_reset_out = !batt_sel[2] && batt_active;
  assign batt_wakeup_out = (batt_sel[2:1] == 2'h2) && batt_active && sleep_mode_in;
  assign batt_evt = (batt_sel[2:1] == 2'h2) && batt_active && !sleep_mode_in;
  assign wakeup_block_out = (batt_sel == cpm_pkg::BATT_SEL_IGNORE) && batt_active
                            && sleep_mode_in;

  // ---------------------------------------------------------------------------
  // Miscellaneous outputs
  // ---------------------------------------------------------------------------
  assign self_refresh_retain_out  = state_reg.misc[cpm_pkg::SELF_REFRESH_BIT];
  assign memclk_out1 = memclk_in && !state_reg.misc[cpm_pkg::MEMCLK1_GATE_BIT];
  assign memclk_out0 = memclk_in && !state_reg.misc[cpm_pkg::MEMCLK0_GATE_BIT];
  assign reset_out_n = state_reg.misc[cpm_pkg::RESET_OUT_BIT];
  assign usb_port1_suspend_out = state_reg.misc[cpm_pkg::USB1_SUSPEND_BIT];
  assign usb_port0_suspend_out = state_reg.misc[cpm_pkg::USB0_SUSPEND_BIT];
  assign usb_pad_role_select_out = state_reg.misc[cpm_pkg::USB_PAD_ROLE_BIT];
  assign upper_bus_pullup_off_out = state_reg.misc[cpm_pkg::UPPER_PULLUP_BIT];
  assign lower_bus_pullup_off_out = state_reg.misc[cpm_pkg::LOWER_PULLUP_BIT];

  // Reserved source codes give a quiet low output rather than a stray clock.
  assign clock_out_pad1 = (src1 <= cpm_pkg::CLKSRC_DIVIDED) ? clock_out_pad1_sources_in[src1] : 1'b0;
  assign clock_out_pad0 = (src0 <= cpm_pkg::CLKSRC_DIVIDED) ? clock_out_pad0_sources_in[src0] : 1'b0;

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (addr_in)
      cpm_pkg::ADDR_MISC_SYSTEM_CONTROL: rd_word = state_reg.misc;
      cpm_pkg::ADDR_PORT_PIN_CONFIG:     rd_word = {6'h00, state_reg.cfg};
      // Input pins show the pin; camera pins show the same, which is undefined to software.
      cpm_pkg::ADDR_PORT_PIN_DATA:       rd_word = {19'h00000,
                                                    (state_reg.dat & out_en)
                                                    | (state_reg.pin_s2 & ~out_en)};
      cpm_pkg::ADDR_PORT_PULLUP_DISABLE: rd_word = {19'h00000, state_reg.pud};
      cpm_pkg::ADDR_IRQ_STATUS:          rd_word = {31'h0000_0000, state_reg.irq_sts};
      cpm_pkg::ADDR_IRQ_MASK:            rd_word = {31'h0000_0000, state_reg.irq_msk};
      default:                           rd_word = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    state_next        = state_reg;
    state_next.pin_s1 = pin_in;
    state_next.pin_s2 = state_reg.pin_s1;
    state_next.bf_s1  = battery_fault_in_n;
    state_next.bf_s2  = state_reg.bf_s1;
    state_next.rdata  = rd_in ? rd_word : 32'h0000_0000;
    if (wr_in)
    begin
      unique case (addr_in)
        cpm_pkg::ADDR_MISC_SYSTEM_CONTROL:
          state_next.misc = wdata_in & cpm_pkg::MISC_WRITE_MASK;
        cpm_pkg::ADDR_PORT_PIN_CONFIG:     state_next.cfg = wdata_in[25:0];
        cpm_pkg::ADDR_PORT_PIN_DATA:       state_next.dat = wdata_in[12:0];
        cpm_pkg::ADDR_PORT_PULLUP_DISABLE: state_next.pud = wdata_in[12:0];
        cpm_pkg::ADDR_IRQ_STATUS:          state_next.irq_sts = state_reg.irq_sts & ~wdata_in[0:0];
        cpm_pkg::ADDR_IRQ_MASK:            state_next.irq_msk = wdata_in[0:0];
        default:                           state_next.misc = state_reg.misc;
      endcase
    end
    // Setting after clearing lets a fault that coincides with a clear survive.
    if (batt_evt)
      state_next.irq_sts[cpm_pkg::IRQ_BATT_FAULT_BIT] = 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_reg         <= '0;
      state_reg.misc    <= cpm_pkg::RST_MISC_SYSTEM_CONTROL;
      state_reg.cfg     <= cpm_pkg::RST_PORT_PIN_CONFIG;
      state_reg.pud     <= cpm_pkg::RST_PORT_PULLUP_DISABLE;
      state_reg.pin_s1  <= 13'h1FFF;
      state_reg.pin_s2  <= 13'h1FFF;
      state_reg.bf_s1   <= 1'b1;
      state_reg.bf_s2   <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata_out = state_reg.rdata;
  assign irq_out = |(state_reg.irq_sts & state_reg.irq_msk);

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_write_data_out: assert property (
    wr_in && addr_in == cpm_pkg::ADDR_PORT_PIN_DATA |=> (pin_out & out_en) == ($past(wdata_in[12:0]) & out_en))
    else $error("output pin does not follow written data");
  a_input_readback: assert property (
    rd_in && addr_in == cpm_pkg::ADDR_PORT_PIN_DATA && !wr_in && state_reg.cfg == 26'h0
    |=> rdata_out[12:0] == $past(state_reg.pin_s2))
    else $error("input readback differs from sampled pins");
  a_pullup_map: assert property (pin_pullup_en_out == ~state_reg.pud)
    else $error("pull-up enable not inverse of disable bits");
  a_oe_mode: assert property (
    state_reg.cfg[1:0] == 2'h0 |-> pin_oe_b_out[0])
    else $error("input pin is being driven");
  a_batt_hold: assert property (
    !batt_sel[2] && !state_reg.bf_s2 |-> batt_hold_reset_out)
    else $error("battery fault not holding reset");
  a_batt_irq: assert property (
    batt_evt |=> state_reg.irq_sts[0])
    else $error("battery interrupt not latched");
  a_batt_off: assert property (
    batt_sel == cpm_pkg::BATT_SEL_OFF |-> !batt_hold_reset_out && !batt_wakeup_out && !wakeup_block_out)
    else $error("disabled battery input had an effect");
  a_memclk_gate: assert property (
    state_reg.misc[cpm_pkg::MEMCLK1_GATE_BIT] |-> !memclk_out1)
    else $error("gated memory clock toggles");
  a_reset_out: assert property (
    wr_in && addr_in == cpm_pkg::ADDR_MISC_SYSTEM_CONTROL |=> reset_out_n == $past(wdata_in[16]))
    else $error("reset-out not following write");

  // ---------------------------------------------------------------------------
  // Assertions per pin, battery fault and register field
  // ---------------------------------------------------------------------------
  // A pin may only be driven in output mode or by the camera logic.
  a_drive_when_enabled: assert property (
    (~pin_oe_b_out & ~(out_en | cam_sel)) == 13'h0000)
    else $error("pin driven outside output or camera mode");

  a_camera_drive: assert property (
    (pin_out & cam_sel) == (camera_func_out_in & cam_sel))
    else $error("camera pin not driven by camera logic");

  a_camera_in_gated: assert property (
    (camera_func_in_out & ~cam_sel) == 13'h0000)
    else $error("camera input shows a non-camera pin");

  a_pullup_write: assert property (
    wr_in && addr_in == cpm_pkg::ADDR_PORT_PULLUP_DISABLE
    |=> pin_pullup_en_out == ~$past(wdata_in[12:0]))
    else $error("pull-up enables do not follow written disable bits");

  // The first edge out of reset must still see the config, pull-up disable and miscellaneous registers at their reset values.
  a_reset_state: assert property (
    $rose(rst_b_in)
    |-> state_reg.cfg == cpm_pkg::RST_PORT_PIN_CONFIG
        && state_reg.pud == cpm_pkg::RST_PORT_PULLUP_DISABLE
        && state_reg.misc == cpm_pkg::RST_MISC_SYSTEM_CONTROL)
    else $error("register not at reset value after reset");

  a_idle_read_zero: assert property (
    !rd_in |=> rdata_out == 32'h0000_0000)
    else $error("read data present without a read strobe");

  a_batt_quiet: assert property (
    state_reg.bf_s2
    |-> !batt_hold_reset_out && !batt_wakeup_out && !wakeup_block_out)
    else $error("battery function active without a fault");

  a_batt_wake: assert property (
    batt_sel[2:1] == 2'h2 && !state_reg.bf_s2 && sleep_mode_in
    |-> batt_wakeup_out && !batt_hold_reset_out && !wakeup_block_out)
    else $error("battery fault did not wake from sleep");

  a_batt_ignore: assert property (
    batt_sel == cpm_pkg::BATT_SEL_IGNORE && !state_reg.bf_s2 && sleep_mode_in
    |-> wakeup_block_out && !batt_wakeup_out)
    else $error("wake-up sources not blocked during fault");

  // In normal mode this selection must leave the system alone.
  a_batt_ignore_run: assert property (
    batt_sel == cpm_pkg::BATT_SEL_IGNORE && !sleep_mode_in
    |-> !wakeup_block_out && !batt_hold_reset_out && !batt_evt)
    else $error("battery fault affected normal mode");

  a_irq_clear: assert property (
    wr_in && addr_in == cpm_pkg::ADDR_IRQ_STATUS && wdata_in[0] && !batt_evt
    |=> !state_reg.irq_sts[cpm_pkg::IRQ_BATT_FAULT_BIT])
    else $error("battery interrupt not cleared by writing one");

  a_irq_sticky: assert property (
    state_reg.irq_sts[cpm_pkg::IRQ_BATT_FAULT_BIT]
    && !(wr_in && addr_in == cpm_pkg::ADDR_IRQ_STATUS && wdata_in[0])
    |=> state_reg.irq_sts[cpm_pkg::IRQ_BATT_FAULT_BIT])
    else $error("battery interrupt status lost without a clear");

  a_misc_reserved: assert property (
    (state_reg.misc & ~cpm_pkg::MISC_WRITE_MASK) == 32'h0000_0000)
    else $error("reserved control bit set");

  a_self_refresh: assert property (
    wr_in && addr_in == cpm_pkg::ADDR_MISC_SYSTEM_CONTROL
    |=> self_refresh_retain_out == $past(wdata_in[cpm_pkg::SELF_REFRESH_BIT]))
    else $error("self-refresh retain not following write");

  a_memclk0_gate: assert property (
    state_reg.misc[cpm_pkg::MEMCLK0_GATE_BIT] |-> !memclk_out0)
    else $error("gated memory clock 0 toggles");

  a_memclk1_pass: assert property (
    !state_reg.misc[cpm_pkg::MEMCLK1_GATE_BIT] |-> memclk_out1 == memclk_in)
    else $error("ungated memory clock 1 not passed");

  a_usb_suspend: assert property (
    wr_in && addr_in == cpm_pkg::ADDR_MISC_SYSTEM_CONTROL
    |=> usb_port1_suspend_out == $past(wdata_in[cpm_pkg::USB1_SUSPEND_BIT])
        && usb_port0_suspend_out == $past(wdata_in[cpm_pkg::USB0_SUSPEND_BIT]))
    else $error("USB suspend outputs not following write");

  // Reserved source codes must not leak a clock onto the pads.
  a_clock_out_pad1_reserved: assert property (
    src1 > cpm_pkg::CLKSRC_DIVIDED |-> !clock_out_pad1)
    else $error("reserved clock-out 1 source drives the pad");

  a_clock_out_pad0_reserved: assert property (
    src0 > cpm_pkg::CLKSRC_DIVIDED |-> !clock_out_pad0)
    else $error("reserved clock-out 0 source drives the pad");

  a_usb_pad_role: assert property (
    wr_in && addr_in == cpm_pkg::ADDR_MISC_SYSTEM_CONTROL
    |=> usb_pad_role_select_out == $past(wdata_in[cpm_pkg::USB_PAD_ROLE_BIT]))
    else $error("USB pad role not following write");

  a_bus_pullups: assert property (
    wr_in && addr_in == cpm_pkg::ADDR_MISC_SYSTEM_CONTROL
    |=> upper_bus_pullup_off_out == $past(wdata_in[cpm_pkg::UPPER_PULLUP_BIT])
        && lower_bus_pullup_off_out == $past(wdata_in[cpm_pkg::LOWER_PULLUP_BIT]))
    else $error("data-bus pull-up controls not following write");

  c_output_write: cover property (wr_in && addr_in == cpm_pkg::ADDR_PORT_PIN_DATA ##1 |out_en);
  c_batt_irq: cover property (batt_evt ##1 irq_out);
  c_camera_mode: cover property (|cam_sel);
  c_irq_clear: cover property (irq_out ##1 wr_in && addr_in == cpm_pkg::ADDR_IRQ_STATUS ##1 !irq_out);
  c_wake_blocked: cover property (sleep_mode_in && wakeup_block_out);

endmodule
`default_nettype wire

//--- verification/cpm_board_model.sv
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------------------
// Board and camera sensor side of the port pins
// -----------------------------------------------------------------------------
// A pin that nobody drives and whose pull-up is off floats. It is shown
// toggling every cycle, so a stale level can never pass for a real one.
module cpm_board_model (
  input  wire logic        clk_in,
  input  wire logic [12:0] pin_out_in,
  input  wire logic [12:0] pin_oe_b_in,
  input  wire logic [12:0] pin_pullup_en_in,
  input  wire logic [12:0] drive_in,
  input  wire logic [12:0] drive_en_in,
  output logic      [12:0] level_out
);
  logic [12:0] float_reg = 13'h0AAA;
  always_ff @(posedge clk_in)
  begin
    float_reg <= ~float_reg;
  end
  always_comb
  begin
    for (int i = 0; i < 13; i++)
    begin
      if (!pin_oe_b_in[i])
        level_out[i] = pin_out_in[i];
      else if (drive_en_in[i])
        level_out[i] = drive_in[i];
      else if (pin_pullup_en_in[i])
        level_out[i] = 1'b1;
      else
        level_out[i] = float_reg[i];
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_camera_port_and_misc_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_camera_port_and_misc_control;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, irq, batt_n = 1'b1, slp = 1'b0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, rv;
  logic [12:0] lvl, po, oeb, pue, csel, cin, cout = 13'h0, coe = 13'h0, drv = 13'h0, den = 13'h0;
  logic hold, wake, blk, sref, mclk = 1'b1, mc1, mc0, rsto_n, u1, u0, pad, co1, co0, upo, lpo;
  logic [5:0] src1 = 6'h0, src0 = 6'h0;
  int mismatches = 0, n_compared = 0;
  cpm_camera_port uut (.clk_in(clk), .rst_b_in(rst_b), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq), .pin_in(lvl), .pin_out(po),
    .pin_oe_b_out(oeb), .pin_pullup_en_out(pue), .pin_camera_sel_out(csel),
    .camera_func_out_in(cout), .camera_func_oe_in(coe), .camera_func_in_out(cin),
    .battery_fault_in_n(batt_n), .sleep_mode_in(slp), .batt_hold_reset_out(hold),
    .batt_wakeup_out(wake), .wakeup_block_out(blk), .self_refresh_retain_out(sref),
    .memclk_in(mclk), .memclk_out1(mc1), .memclk_out0(mc0), .reset_out_n(rsto_n),
    .usb_port1_suspend_out(u1), .usb_port0_suspend_out(u0), .usb_pad_role_select_out(pad),
    .clock_out_pad1_sources_in(src1), .clock_out_pad0_sources_in(src0), .clock_out_pad1(co1),
    .clock_out_pad0(co0), .upper_bus_pullup_off_out(upo), .lower_bus_pullup_off_out(lpo));
  cpm_board_model board (.clk_in(clk), .pin_out_in(po), .pin_oe_b_in(oeb),
    .pin_pullup_en_in(pue), .drive_in(drv), .drive_en_in(den), .level_out(lvl));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_reset;
    rd_reg(cpm_pkg::ADDR_MISC_SYSTEM_CONTROL, rv);
    chk("misc reset", rv, 32'h0001_0020);
    rd_reg(cpm_pkg::ADDR_PORT_PIN_CONFIG, rv);
    chk("config reset", rv, 32'h0);
    rd_reg(cpm_pkg::ADDR_PORT_PULLUP_DISABLE, rv);
    chk("pullup reset", rv, 32'h0);
    rd_reg(32'h5600_00DC, rv);
    chk("unmapped read", rv, 32'h0);
    chk("pullups on", pue, 13'h1FFF);
    chk("all inputs", oeb, 13'h1FFF);
    chk("reset out", rsto_n, 1'b1);
    @(posedge clk);
    src0 <= 6'h04;
    wait_cyc(1);
    chk("clock_out_pad0 reset src", co0, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_pins;
    @(posedge clk);
    den <= 13'h1FFF;
    drv <= 13'h0A5A;
    coe <= 13'h1FFF;
    cout <= 13'h0100;
    wr_reg(cpm_pkg::ADDR_PORT_PIN_DATA, 32'h0000_1FF5);
    wr_reg(cpm_pkg::ADDR_PORT_PIN_CONFIG, 32'h000E_0055);
    chk("enables", oeb, 13'h1EF0);
    chk("drive", po & 13'h010F, 13'h0105);
    chk("camera sel", csel, 13'h0100);
    wait_cyc(3);
    rd_reg(cpm_pkg::ADDR_PORT_PIN_DATA, rv);
    chk("data read", rv & 32'h1CFF, 32'h0855);
    chk("camera in", cin, 13'h0100);
    wr_reg(cpm_pkg::ADDR_PORT_PIN_CONFIG, 32'h0);
    $display("test pins done");
  endtask
  task automatic t_pullup;
    wr_reg(cpm_pkg::ADDR_PORT_PULLUP_DISABLE, 32'h0000_0AAA);
    chk("pullup en", pue, 13'h1555);
    rd_reg(cpm_pkg::ADDR_PORT_PULLUP_DISABLE, rv);
    chk("pullup read", rv, 32'h0000_0AAA);
    $display("test pullup done");
  endtask
  task automatic t_misc;
    int pos [9] = '{19, 18, 17, 16, 13, 12, 3, 1, 0};
    logic [31:0] m;
    wr_reg(cpm_pkg::ADDR_MISC_SYSTEM_CONTROL, 32'hFFFF_FFFF);
    rd_reg(cpm_pkg::ADDR_MISC_SYSTEM_CONTROL, rv);
    chk("misc reserved", rv, cpm_pkg::MISC_WRITE_MASK);
    for (int i = 0; i < 18; i++)
    begin
      m = 32'h0001_0020 ^ (32'h1 << pos[i % 9]);
      @(posedge clk);
      mclk <= i[0];
      wr_reg(cpm_pkg::ADDR_MISC_SYSTEM_CONTROL, m);
      chk("misc outs", {sref, mc1, mc0, rsto_n, u1, u0, pad, upo, lpo}, {m[19],
        ~m[18] & mclk, ~m[17] & mclk, m[16], m[13], m[12], m[3], m[1], m[0]});
    end
    $display("test misc done");
  endtask
  task automatic t_clksel;
    logic [5:0] oh;
    for (int c = 0; c < 8; c++)
    begin
      oh = (c < 6) ? (6'h01 << c) : 6'h3F;
      @(posedge clk);
      src1 <= oh;
      src0 <= oh;
      wr_reg(cpm_pkg::ADDR_MISC_SYSTEM_CONTROL, 32'h0001_0000 | (c << 8) | (c << 4));
      chk("clkout sel", {co1, co0}, {2{c < 6}});
      @(posedge clk);
      src1 <= 6'h3F ^ oh;
      src0 <= 6'h3F ^ oh;
      wait_cyc(1);
      chk("clkout other", {co1, co0}, 2'b00);
    end
    $display("test clksel done");
  endtask
  task automatic t_batt;
    logic [2:0] s;
    @(posedge clk);
    batt_n <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      s = i[3:1];
      @(posedge clk);
      slp <= i[0];
      wr_reg(cpm_pkg::ADDR_MISC_SYSTEM_CONTROL, 32'h0001_0020 | (s << 20));
      wait_cyc(3);
      chk("batt", {hold, wake, blk}, {!s[2], s[2:1] == 2'b10 && slp, s == 3'h6 && slp});
      chk("irq masked", irq, 1'b0);
    end
    rd_reg(cpm_pkg::ADDR_IRQ_STATUS, rv);
    chk("irq status", rv, 32'h1);
    wr_reg(cpm_pkg::ADDR_IRQ_MASK, 32'h1);
    chk("irq on", irq, 1'b1);
    wr_reg(cpm_pkg::ADDR_IRQ_STATUS, 32'h1);
    chk("irq cleared", irq, 1'b0);
    @(posedge clk);
    slp <= 1'b0;
    wr_reg(cpm_pkg::ADDR_MISC_SYSTEM_CONTROL, 32'h0041_0020);
    for (int k = 0; k < 8 && irq !== 1'b1; k++)
      wait_cyc(1);
    chk("irq event", irq, 1'b1);
    wr_reg(cpm_pkg::ADDR_IRQ_STATUS, 32'h1);
    chk("set wins", irq, 1'b1);
    @(posedge clk);
    batt_n <= 1'b1;
    wait_cyc(3);
    chk("fault gone", {hold, wake, blk}, 3'b000);
    wr_reg(cpm_pkg::ADDR_IRQ_STATUS, 32'h1);
    chk("irq clear", irq, 1'b0);
    $display("test batt done");
  endtask
  task automatic t_rerun_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    wait_cyc(2);
    chk("pullups in reset", pue, 13'h1FFF);
    @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(cpm_pkg::ADDR_PORT_PULLUP_DISABLE, rv);
    chk("pullup after reset", rv, 32'h0);
    rd_reg(cpm_pkg::ADDR_PORT_PIN_DATA, rv);
    chk("inputs after reset", rv, 32'h0000_0A5A);
    $display("test rerun reset done");
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_pins();
    t_pullup();
    t_rerun_reset();
    t_misc();
    t_clksel();
    t_batt();
    complete_run();
  end
endmodule
`default_nettype wire
